// ===== logic/abc_pkg.sv
package abc_pkg;

    // ==========================================================
    // register offsets (byte pointer values on the serial bus)
    localparam logic [7:0] OFF_SYSTEM_CONTROL = 8'h01;
    localparam logic [7:0] OFF_BATTERY_GUARD  = 8'h02;
    localparam logic [7:0] OFF_STEP_UP_VOLT   = 8'h03;
    localparam logic [7:0] OFF_STEP_UP_CURR   = 8'h05;
    localparam logic [7:0] OFF_AMP_GAIN       = 8'h06;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h38;
    localparam logic [7:0] RST_BATTERY_GUARD  = 8'h09;
    localparam logic [7:0] RST_STEP_UP_VOLT   = 8'h0c;
    localparam logic [7:0] RST_STEP_UP_CURR   = 8'h08;
    localparam logic [7:0] RST_AMP_GAIN       = 8'h10;
    localparam logic [7:0] RD_UNMAPPED        = 8'h00;

    // ==========================================================
    // field positions: system control
    localparam int SYS_SOFT_EN_BIT  = 6;
    localparam int SYS_STEP_UP_BIT  = 4;
    localparam int SYS_AMP_EN_BIT   = 3;
    localparam int SYS_EARPIECE_BIT = 2;
    localparam int SYS_HIGH_BAT_BIT = 0;

    // field positions: battery guard
    localparam int GRD_FILTER_LSB  = 5;
    localparam int GRD_ENTRY_LSB   = 3;
    localparam int GRD_ENABLE_BIT  = 2;
    localparam int GRD_CEILING_LSB = 0;

    // field widths
    localparam int VOLT_CODE_W = 5;
    localparam int CURR_CODE_W = 4;
    localparam int GAIN_CODE_W = 5;

    // ==========================================================
    // bus address: upper five bits fixed, lower two from the strap
    localparam logic [4:0] DEV_ADDR_HI = 5'h16;

endpackage

// ===== logic/abc_sync2.sv
`timescale 1ns/1ps
// ==========================================================
// two-flop synchroniser for a bundle of asynchronous levels
module abc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;

    // first stage is read only by the second
    always_ff @(posedge clk) begin
        if (reset) begin
            meta     <= '1;
            sync_out <= '1;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ===== logic/abc_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - soft enable b6, step-up b4, amp b3, earpiece b2, high battery b0; reset 0x38
// - guard filter bits 6:5: 1ms, 500us, 200us, code 11 disables; reset 00
// - guard entry level bits 4:3: 3.3V to 3.6V; reset 01
// - guard enable bit 2, active high, resets to 0
// - guard output ceiling bits 1:0: 5V to 6.5V; reset 01
// - step-up voltage code n gives 6.5V plus n*0.25V; reset 01100
// - step-up current code 0010 is 2A, 0.25A steps to 4.5A; reset 1000
// - gain code 0dB at zero, 1.5dB per step; reset 10000
// - high battery enable in system control bit 0, resets to 0
// - register pointer advances once after each data byte, including a read byte the master nacks
// - answer bus address 10110 plus strap bits; register address comes first
module abc_regs
    import abc_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   scl,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe,
    input  wire logic [1:0]             addr_strap,
    output logic                        chip_soft_enable,
    output logic                        step_up_enable,
    output logic                        amplifier_enable,
    output logic                        earpiece_mode,
    output logic                        high_batt_enable,
    output logic [1:0]                  guard_filter_time,
    output logic [1:0]                  guard_entry_level,
    output logic                        guard_enable,
    output logic [1:0]                  guard_output_ceiling,
    output logic [abc_pkg::VOLT_CODE_W-1:0] step_up_voltage_code,
    output logic [abc_pkg::CURR_CODE_W-1:0] step_up_current_code,
    output logic [abc_pkg::GAIN_CODE_W-1:0] amplifier_gain_code
);
    import abc_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_ACK, ST_TX, ST_MACK
    } abc_state_e;

    // ==========================================================
    // pin synchronisation and bus event detection
    logic [3:0] pins_s;
    logic       scl_q;
    logic       sda_q;
    logic [1:0] strap_q;

    abc_sync2 #(.W(4)) u_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in ({scl, sda_in, addr_strap}),
        .sync_out (pins_s)
    );

    wire       scl_s    = pins_s[3];
    wire       sda_s    = pins_s[2];
    wire       scl_rise = scl_s & ~scl_q;
    wire       scl_fall = ~scl_s & scl_q;
    wire       bus_start = scl_s & scl_q & sda_q & ~sda_s;
    wire       bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

    // delayed copies for edge detection; the strap is followed all the time,
    // because the synchroniser shows all ones while reset is held
    always_ff @(posedge clk) begin
        scl_q   <= scl_s;
        sda_q   <= sda_s;
        strap_q <= pins_s[1:0];
    end

    // ==========================================================
    // register storage
    logic [7:0] system_control;
    logic [7:0] battery_guard_config;
    logic [7:0] step_up_voltage_select;
    logic [7:0] step_up_current_limit;
    logic [7:0] amplifier_gain_control;

    // ==========================================================
    // serial protocol state
    abc_state_e state;
    abc_state_e after_ack;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx_sh;
    logic [7:0] reg_ptr;
    logic       ack_on;
    logic       inc_ptr;
    logic       mack_ok;

    wire [7:0] rx_byte  = {shift[6:0], sda_s};
    wire       addr_hit = (rx_byte[7:1] == {DEV_ADDR_HI, strap_q});
    wire       byte_end = scl_rise & (bit_cnt == 3'd7);
    wire       wr_strobe = byte_end & (state == ST_WDATA);

    // read mux over the mapped offsets, zero elsewhere
    wire [7:0] rd_byte =
        (reg_ptr == OFF_SYSTEM_CONTROL) ? system_control :
        (reg_ptr == OFF_BATTERY_GUARD)  ? battery_guard_config :
        (reg_ptr == OFF_STEP_UP_VOLT)   ? step_up_voltage_select :
        (reg_ptr == OFF_STEP_UP_CURR)   ? step_up_current_limit :
        (reg_ptr == OFF_AMP_GAIN)       ? amplifier_gain_control : RD_UNMAPPED;

    // next pointer value seen by the read that follows a master ack
    wire [7:0] next_ptr = reg_ptr + 8'h01;

    // ==========================================================
    // register writes; every bit is stored, spare ones included
    always_ff @(posedge clk) begin
        if (reset) begin
            system_control         <= RST_SYSTEM_CONTROL;
            battery_guard_config   <= RST_BATTERY_GUARD;
            step_up_voltage_select <= RST_STEP_UP_VOLT;
            step_up_current_limit  <= RST_STEP_UP_CURR;
            amplifier_gain_control <= RST_AMP_GAIN;
        end else if (wr_strobe) begin
            if (reg_ptr == OFF_SYSTEM_CONTROL) system_control <= rx_byte;
            if (reg_ptr == OFF_BATTERY_GUARD)  battery_guard_config <= rx_byte;
            if (reg_ptr == OFF_STEP_UP_VOLT)   step_up_voltage_select <= rx_byte;
            if (reg_ptr == OFF_STEP_UP_CURR)   step_up_current_limit <= rx_byte;
            if (reg_ptr == OFF_AMP_GAIN)       amplifier_gain_control <= rx_byte;
        end
    end

    // ==========================================================
    // slave state machine: sample on scl rise, drive on scl fall
    always_ff @(posedge clk) begin
        if (reset) begin
            state     <= ST_IDLE;
            after_ack <= ST_IDLE;
            bit_cnt   <= 3'd0;
            shift     <= 8'h00;
            tx_sh     <= 8'h00;
            reg_ptr   <= 8'h00;
            ack_on    <= 1'b0;
            inc_ptr   <= 1'b0;
            mack_ok   <= 1'b0;
            sda_oe    <= 1'b0;
        end else if (bus_start) begin
            state   <= ST_ADDR;
            bit_cnt <= 3'd0;
            ack_on  <= 1'b0;
            sda_oe  <= 1'b0;
        end else if (bus_stop) begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise) begin
                        shift   <= rx_byte;
                        bit_cnt <= bit_cnt + 3'd1;
                    end
                    if (byte_end) begin
                        ack_on  <= 1'b0;
                        inc_ptr <= (state == ST_WDATA);
                        if (state == ST_ADDR) begin
                            state     <= addr_hit ? ST_ACK : ST_IDLE;
                            after_ack <= rx_byte[0] ? ST_TX : ST_REG;
                        end else begin
                            state     <= ST_ACK;
                            after_ack <= ST_WDATA;
                            if (state == ST_REG) begin
                                reg_ptr <= rx_byte;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall && !ack_on) begin
                        ack_on <= 1'b1;
                        sda_oe <= 1'b1;          // pull low for ack
                    end else if (scl_fall) begin
                        ack_on  <= 1'b0;
                        state   <= after_ack;
                        bit_cnt <= 3'd0;
                        sda_oe  <= (after_ack == ST_TX) ? ~rd_byte[7] : 1'b0;
                        tx_sh   <= rd_byte;
                        if (inc_ptr) begin
                            reg_ptr <= next_ptr;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == 3'd7) begin
                            sda_oe  <= 1'b0;
                            state   <= ST_MACK;
                            bit_cnt <= 3'd0;
                            ack_on  <= 1'b0;
                        end else begin
                            sda_oe  <= ~tx_sh[6];
                            tx_sh   <= {tx_sh[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 3'd1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        ack_on  <= 1'b1;
                        mack_ok <= ~sda_s;
                        reg_ptr <= next_ptr;
                    end else if (scl_fall && ack_on) begin
                        ack_on  <= 1'b0;
                        state   <= mack_ok ? ST_TX : ST_IDLE;
                        sda_oe  <= mack_ok & ~rd_byte[7];
                        tx_sh   <= rd_byte;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // field outputs taken straight from flops; the sda_out pin is a constant low
    assign sda_out              = 1'b0;  // open drain: only low is driven
    assign chip_soft_enable     = system_control[SYS_SOFT_EN_BIT];
    assign step_up_enable       = system_control[SYS_STEP_UP_BIT];
    assign amplifier_enable     = system_control[SYS_AMP_EN_BIT];
    assign earpiece_mode        = system_control[SYS_EARPIECE_BIT];
    assign high_batt_enable     = system_control[SYS_HIGH_BAT_BIT];
    assign guard_filter_time    = battery_guard_config[GRD_FILTER_LSB +: 2];
    assign guard_entry_level    = battery_guard_config[GRD_ENTRY_LSB +: 2];
    assign guard_enable         = battery_guard_config[GRD_ENABLE_BIT];
    assign guard_output_ceiling = battery_guard_config[GRD_CEILING_LSB +: 2];
    assign step_up_voltage_code = step_up_voltage_select[VOLT_CODE_W-1:0];
    assign step_up_current_code = step_up_current_limit[CURR_CODE_W-1:0];
    assign amplifier_gain_code  = amplifier_gain_control[GAIN_CODE_W-1:0];
endmodule

// ===== bench/abc_regs_properties.sv
`timescale 1ns/1ps
// ==========================================================
// port checks for the register bank
module abc_regs_props
    import abc_pkg::*;
(
    input wire logic                            clk,
    input wire logic                            reset,
    input wire logic                            scl,
    input wire logic                            sda_out,
    input wire logic                            sda_oe,
    input wire logic                            chip_soft_enable,
    input wire logic                            step_up_enable,
    input wire logic                            amplifier_enable,
    input wire logic                            earpiece_mode,
    input wire logic                            high_batt_enable,
    input wire logic [1:0]                      guard_filter_time,
    input wire logic [1:0]                      guard_entry_level,
    input wire logic                            guard_enable,
    input wire logic [1:0]                      guard_output_ceiling,
    input wire logic [abc_pkg::VOLT_CODE_W-1:0] step_up_voltage_code,
    input wire logic [abc_pkg::CURR_CODE_W-1:0] step_up_current_code,
    input wire logic [abc_pkg::GAIN_CODE_W-1:0] amplifier_gain_code
);
    // all field outputs in one vector
    wire [25:0] outs = {chip_soft_enable, step_up_enable, amplifier_enable, earpiece_mode, high_batt_enable,
        guard_filter_time, guard_entry_level, guard_enable, guard_output_ceiling,
        step_up_voltage_code, step_up_current_code, amplifier_gain_code};

    // ==========================================================
    // assertions
    property p_sda_low; @(posedge clk) disable iff (reset) sda_oe |-> sda_out == 1'b0; endproperty
    a_sda_low: assert property (p_sda_low) else $error("sda driven high");
    property p_sda_hold; @(posedge clk) disable iff (reset) scl && $past(scl) |-> $stable(sda_oe); endproperty
    a_sda_hold: assert property (p_sda_hold) else $error("sda moved with clock high");
    property p_oe_rst; @(posedge clk) reset |=> !sda_oe; endproperty
    a_oe_rst: assert property (p_oe_rst) else $error("sda driven in reset");
    property p_rst_sys; @(posedge clk) reset |=> outs[25:21] == 5'b01100; endproperty
    a_rst_sys: assert property (p_rst_sys) else $error("system control reset wrong");
    property p_rst_grd; @(posedge clk) reset |=> outs[20:14] == 7'b0001001; endproperty
    a_rst_grd: assert property (p_rst_grd) else $error("guard reset wrong");
    property p_rst_code; @(posedge clk) reset |=> outs[13:0] == {5'h0c, 4'h8, 5'h10}; endproperty
    a_rst_code: assert property (p_rst_code) else $error("code reset wrong");
    property p_hold_ack; @(posedge clk) disable iff (reset) sda_oe |-> $stable(outs); endproperty
    a_hold_ack: assert property (p_hold_ack) else $error("field moved while driving");
    property p_oe_rise; @(posedge clk) disable iff (reset) $rose(sda_oe) |-> !scl ##1 sda_oe [*4]; endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("sda drive start bad");
    property p_oe_fall; @(posedge clk) disable iff (reset) $fell(sda_oe) |-> !scl && !$past(scl); endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("sda released with clock high");
endmodule

bind abc_regs abc_regs_props u_props (.clk(clk), .reset(reset), .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_soft_enable(chip_soft_enable), .step_up_enable(step_up_enable), .amplifier_enable(amplifier_enable),
    .earpiece_mode(earpiece_mode), .high_batt_enable(high_batt_enable), .guard_filter_time(guard_filter_time),
    .guard_entry_level(guard_entry_level), .guard_enable(guard_enable),
    .guard_output_ceiling(guard_output_ceiling), .step_up_voltage_code(step_up_voltage_code),
    .step_up_current_code(step_up_current_code), .amplifier_gain_code(amplifier_gain_code));

// ===== bench/abc_host.sv
`timescale 1ns/1ps
// ==========================================================
// serial bus master, clock stands high between frames
module abc_host (
    input  wire logic clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_low
);
    // idle bus: both lines released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // one phase of the serial clock
    task automatic half();
        repeat (6) @(posedge clk);
    endtask
    // one bit: data set while clock low, sampled at end of high phase
    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        half();
        scl <= 1'b1;
        half();
        r = sda_wire;
        scl <= 1'b0;
        half();
    endtask
    // start or repeated start: data falls while clock high
    task automatic start_c();
        sda_low <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_low <= 1'b1;
        half();
        scl <= 1'b0;
        half();
    endtask
    // stop: data rises while clock high
    task automatic stop_c();
        sda_low <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_low <= 1'b0;
        half();
    endtask
    // byte msb first plus acknowledge bit
    task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx, output logic ar);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(ab, ar);
    endtask
endmodule

// ===== bench/amp_boost_config_regs_test.sv
`timescale 1ns/1ps
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %0t %s", $time, m); end end
module amp_boost_config_regs_test;
    import abc_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [1:0]  strap = 2'b10;
    logic        scl;
    logic        sda_low;
    logic        sda_oe;
    logic        sda_out;
    wire  [25:0] outs;
    wire         sda_wire = (sda_oe ? sda_out : 1'b1) & !sda_low;
    int          n_errors = 0;
    int          cmp_count = 0;
    logic [7:0]  lf = 8'h30;
    logic [7:0]  wd [1:6];
    logic [7:0]  em [1:6];
    logic [95:0] corners = {48'hc7fff6abfce7, 48'h000000000208};

    always #5 clk = ~clk;

    abc_regs dut (.clk(clk), .reset(reset), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap(strap), .chip_soft_enable(outs[25]), .step_up_enable(outs[24]), .amplifier_enable(outs[23]),
        .earpiece_mode(outs[22]), .high_batt_enable(outs[21]), .guard_filter_time(outs[20:19]),
        .guard_entry_level(outs[18:17]), .guard_enable(outs[16]), .guard_output_ceiling(outs[15:14]),
        .step_up_voltage_code(outs[13:9]), .step_up_current_code(outs[8:5]), .amplifier_gain_code(outs[4:0]));
    abc_host host (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));

    // ==========================================================
    // helpers
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic logic [25:0] fields(input logic [7:0] s, b, v, c, g);
        return {s[6], s[4], s[3], s[2], s[0], b[6:0], v[4:0], c[3:0], g[4:0]};
    endfunction
    task automatic give_verdict();
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // address phase and pointer, register address before data
    task automatic head();
        logic [7:0] rx;
        logic       ak;
        host.start_c();
        host.xfer({DEV_ADDR_HI, strap, 1'b0}, 1'b1, rx, ak);
        `CHK(ak, 1'b0, "address not acknowledged")
        host.xfer(OFF_SYSTEM_CONTROL, 1'b1, rx, ak);
        `CHK(ak, 1'b0, "pointer not acknowledged")
    endtask
    // burst write of offsets 0x01 to 0x06, pointer advancing
    task automatic wr_all();
        logic [7:0] rx;
        logic       ak;
        head();
        for (int i = 1; i < 7; i++) begin
            host.xfer(wd[i], 1'b1, rx, ak);
            `CHK(ak, 1'b0, "data not acknowledged")
        end
        host.stop_c();
    endtask
    // burst read after repeated start, nack on last byte
    task automatic rd_all();
        logic [7:0] rx;
        logic       ak;
        head();
        host.start_c();
        host.xfer({DEV_ADDR_HI, strap, 1'b1}, 1'b1, rx, ak);
        `CHK(ak, 1'b0, "read address not acknowledged")
        for (int i = 1; i < 7; i++) begin
            host.xfer(8'hff, i == 6, rx, ak);
            `CHK(rx, em[i], "read back differs")
        end
        host.stop_c();
    endtask

    // ==========================================================
    // main sequence
    initial begin
        logic [7:0]  rx;
        logic        ak;
        logic [25:0] want;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        want = fields(RST_SYSTEM_CONTROL, RST_BATTERY_GUARD, RST_STEP_UP_VOLT, RST_STEP_UP_CURR, RST_AMP_GAIN);
        `CHK(outs, want, "reset fields")
        em = '{RST_SYSTEM_CONTROL, RST_BATTERY_GUARD, RST_STEP_UP_VOLT, RD_UNMAPPED, RST_STEP_UP_CURR, RST_AMP_GAIN};
        rd_all();
        // foreign strap must be ignored
        host.start_c();
        host.xfer({DEV_ADDR_HI, ~strap, 1'b0}, 1'b1, rx, ak);
        `CHK(ak, 1'b1, "foreign address acknowledged")
        host.stop_c();
        for (int k = 0; k < 6; k++) begin
            for (int i = 1; i < 7; i++) begin
                lf = lfsr(lf);
                wd[i] = (k < 2) ? corners[48 * (1 - k) + 8 * (6 - i) +: 8] : lf;
            end
            // gain kept inside the range of the chosen earpiece mode
            if (k > 1) wd[6][4:0] = wd[1][2] ? {2'b00, wd[6][2:0]} : 5'h08 + 5'(wd[6] % 8'd11);
            em = '{wd[1], wd[2], wd[3], RD_UNMAPPED, wd[5], wd[6]};
            wr_all();
            want = fields(wd[1], wd[2], wd[3], wd[5], wd[6]);
            `CHK(outs, want, "fields after write")
            rd_all();
        end
        give_verdict();
    end

    // watchdog against a hung run
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
endmodule
